// ==== core/paos_regs.vh ====
// paos_regs.vh: constants for the array output stage
// assumes inclusion by core/paos_core.v only
`ifndef PAOS_REGS_VH
`define PAOS_REGS_VH
`define PAOS_NUM_INPUTS    8
`define PAOS_NUM_STORE     8
`define PAOS_GROUP_SIZE    4
`define PAOS_NUM_TERMS     8
`define PAOS_MODE_REG      1'b0
`define PAOS_MODE_LATCH    1'b1
`define PAOS_RST_STORE     8'h00
`endif

// ==== core/paos_core.v ====
// paos_core.v: output stage of a sum-of-products array device
// assumes all pins come from outside and are synchronised here on i_clk_sys
// latches are modelled as transparency sampled on i_clk_sys
// clear and output gate act on their synchronised levels
//
// Summary of operation
// R1: eight storage outputs, or four plus four I/O
// R2: dual variants split storage into two groups
// R3: clock a loads group a, clock b group b
// R4: common variants OR both clocks together
// R5: registers load on rising effective clock edge
// R6: latch enables split or ORed like clocks
// R7: latch transparent while effective enable low
// R8: master clear forces all storage low
// R9: output enable high drives stored outputs low
// R10: output enable never disturbs contents or feedback
// R11: I/O pins drive result and feed back
// R12: eight dedicated inputs feed the array
// R13: latch holds while effective enable high
// R14: empty term high, contradictory term low
// R15: storage stays low after clear until loaded
`timescale 1ns/1ns
`default_nettype none
`include "paos_regs.vh"
module paos_core #(
  parameter       NI        = `PAOS_NUM_INPUTS,
  parameter       NT        = `PAOS_NUM_TERMS,
  parameter [0:0] LATCH_MODE = `PAOS_MODE_REG,
  parameter [0:0] DUAL_CLK   = 1'b0,
  parameter [0:0] MIXED      = 1'b0,
  // per output, per term: true and complement masks over 16 array inputs
  parameter [8*NT*16-1:0] TRUE_MASK = {8*NT*16{1'b1}},
  parameter [8*NT*16-1:0] COMP_MASK = {8*NT*16{1'b1}},
  parameter [8*NT-1:0]    TERM_USED = {8*NT{1'b0}},
  parameter [7:0]         POL_INV   = 8'h00
) (
  input  wire          i_clk_sys,
  input  wire          i_rst,
  input  wire          i_ce,
  input  wire [NI-1:0] i_data,
  input  wire          i_clock_group_a,
  input  wire          i_clock_group_b,
  input  wire          i_master_clear,
  input  wire          i_out_disable,
  input  wire [3:0]    i_io,
  output reg  [7:0]    o_q,
  output reg  [3:0]    o_io,
  output reg  [3:0]    o_io_oe
);
  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  localparam       NW    = NI + 8;
  localparam       NA    = 16;
  localparam       GS    = `PAOS_GROUP_SIZE;
  localparam       NG    = `PAOS_NUM_STORE / `PAOS_GROUP_SIZE;
  localparam [7:0] RST_Q = `PAOS_RST_STORE;
  // group b storage exists only on the eight-output variants
  localparam [1:0] GRP_LIVE = MIXED ? 2'h1 : 2'h3;   // [R1]

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // every pin is asynchronous to i_clk_sys: two flops per bit
  wire [NW-1:0] pin_raw;
  wire [NW-1:0] pin_sync;
  assign pin_raw = {i_io, i_out_disable, i_master_clear,
                    i_clock_group_b, i_clock_group_a, i_data};

  genvar gp;
  generate
    for (gp = 0; gp < NW; gp = gp + 1) begin : g_sync
      reg meta_r;
      reg sync_r;
      always @(posedge i_clk_sys) begin
        if (i_rst) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else if (i_ce) begin
          meta_r <= pin_raw[gp];
          sync_r <= meta_r;
        end
      end
      assign pin_sync[gp] = sync_r;
    end
  endgenerate

  wire [NI-1:0] din  = pin_sync[NI-1:0];      // [R12]
  wire          clka = pin_sync[NI];
  wire          clkb = pin_sync[NI+1];
  wire          mclr = pin_sync[NI+2];
  wire          odis = pin_sync[NI+3];
  wire [3:0]    iofb = pin_sync[NI+7:NI+4];   // [R11]

  // ----------------------------------------------------------------
  // product term array
  // ----------------------------------------------------------------
  reg  [7:0]    q_r;
  wire [7:0]    fb_src;
  wire [NA-1:0] arr_in;
  wire [7:0]    sum;

  // stored feedback is taken ahead of the output gate [R10]
  assign fb_src = MIXED ? {iofb, q_r[3:0]} : q_r;   // [R11]
  assign arr_in = {fb_src, din[7:0]};

  // one product term: unused is low, all fuses open is high [R14]
  function term_val;
    input [15:0] tm;
    input [15:0] cm;
    input        used;
    input [15:0] v;
    begin
      term_val = used & (&(~tm | v)) & (&(~cm | ~v));
    end
  endfunction

  genvar go, gt;
  generate
    for (go = 0; go < 8; go = go + 1) begin : g_out
      wire [NT-1:0] terms;
      for (gt = 0; gt < NT; gt = gt + 1) begin : g_term
        assign terms[gt] = term_val(TRUE_MASK[(go*NT+gt)*16 +: 16],
                                    COMP_MASK[(go*NT+gt)*16 +: 16],
                                    TERM_USED[go*NT+gt], arr_in);  // [R14]
      end
      assign sum[go] = (|terms) ^ POL_INV[go];
    end
  endgenerate

  // ----------------------------------------------------------------
  // effective clocks and enables
  // ----------------------------------------------------------------
  // own pin on dual parts, both pins ORed on common parts
  function grp_clk;
    input dual;
    input own;
    input other;
    begin
      grp_clk = dual ? own : (own | other);
    end
  endfunction

  // registers load on a rising edge, latches pass while low
  function grp_load;
    input latch;
    input now;
    input prev;
    begin
      grp_load = latch ? ~now : (now & ~prev);
    end
  endfunction

  wire [NG-1:0] grp_en;
  reg  [NG-1:0] grp_en_d_r;
  wire [NG-1:0] grp_ld;

  assign grp_en[0] = grp_clk(DUAL_CLK, clka, clkb);  // [R2] [R3] [R4] [R6]
  assign grp_en[1] = grp_clk(DUAL_CLK, clkb, clka);  // [R2] [R3] [R4] [R6]

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      grp_en_d_r <= {NG{1'b0}};
    end else if (i_ce) begin
      grp_en_d_r <= grp_en;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  wire [7:0] q_nxt;

  genvar gg;
  generate
    for (gg = 0; gg < NG; gg = gg + 1) begin : g_grp
      assign grp_ld[gg] = GRP_LIVE[gg] & grp_load(LATCH_MODE, grp_en[gg],
                                                  grp_en_d_r[gg]);  // [R5] [R7] [R13]
      // clear overrides any load
      assign q_nxt[gg*GS +: GS] = mclr       ? RST_Q[gg*GS +: GS] :  // [R8] [R15]
                                  grp_ld[gg] ? sum[gg*GS +: GS]   :
                                               q_r[gg*GS +: GS];
    end
  endgenerate

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      q_r <= RST_Q;
    end else if (i_ce) begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // the gate only blanks o_q; storage, feedback and the I/O pins run on
  wire [7:0] q_shown;
  wire [7:0] q_drive;
  wire [3:0] io_val;
  wire [3:0] io_en;

  assign q_shown = MIXED ? {4'h0, q_nxt[3:0]} : q_nxt;   // [R1]
  assign q_drive = odis ? 8'h00 : q_shown;               // [R9] [R10]
  assign io_val  = MIXED ? sum[7:4] : 4'h0;              // [R11]
  assign io_en   = MIXED ? 4'hF : 4'h0;                  // [R1] [R11]

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_q <= 8'h00;
    end else if (i_ce) begin
      o_q <= q_drive;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_io    <= 4'h0;
      o_io_oe <= 4'h0;
    end else if (i_ce) begin
      o_io    <= io_val;
      o_io_oe <= io_en;
    end
  end
endmodule
`default_nettype wire

// ==== tb/paos_core_properties.sv ====
// paos_core_properties.sv: port checks on the output stage
// assumes register mode, common clock, no I/O pins
`timescale 1ns/1ns
`default_nettype none
module paos_core_properties (
  input wire       i_clk_sys,
  input wire       i_rst,
  input wire       i_ce,
  input wire [7:0] i_data,
  input wire       i_clock_group_a,
  input wire       i_clock_group_b,
  input wire       i_master_clear,
  input wire       i_out_disable,
  input wire [7:0] o_q,
  input wire [3:0] o_io,
  input wire [3:0] o_io_oe
);
  wire clk_or = i_clock_group_a | i_clock_group_b;
  wire quiet  = i_ce & ~i_master_clear & ~i_out_disable;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  chk_clear_low: assert property ((i_ce & i_master_clear)[*4] |-> o_q == 8'h00)
    else $error("clear left o_q set");
  chk_disable_low: assert property ((i_ce & i_out_disable)[*4] |-> o_q == 8'h00)
    else $error("disable left o_q set");
  chk_load_edge: assert property ($rose(clk_or) && quiet ##1
    ($stable(i_data) && quiet && clk_or)[*4] |-> o_q == i_data) else $error("load missed");
  chk_hold_low: assert property ((quiet & ~clk_or)[*6] |-> $stable(o_q))
    else $error("o_q moved with clock low");
  chk_hold_high: assert property ((quiet & clk_or)[*6] |-> $stable(o_q))
    else $error("o_q moved with clock high");
  chk_reset_zero: assert property (disable iff (1'b0) i_rst && i_ce |=> o_q == 8'h00)
    else $error("reset left o_q set");
  chk_io_released: assert property (o_io_oe == 4'h0)
    else $error("io driven on storage variant");
  chk_io_quiet: assert property (o_io == 4'h0)
    else $error("io value on storage variant");
  chk_ce_freeze: assert property (!i_ce |=> $stable(o_q))
    else $error("o_q moved with enable low");
endmodule
bind paos_core paos_core_properties u_chk (.*);
`default_nettype wire

// ==== tb/paos_sys_model.sv ====
// paos_sys_model.sv: system logic driving the stage pins
// assumes the bench calls drive() for every pin change
`timescale 1ns/1ns
`default_nettype none
module paos_sys_model (
  input  wire              i_clk_sys,
  output var logic [11:0]  o_pins
);
  initial o_pins = 12'h000;
  // pins change a fixed delay after the rising edge
  task automatic drive(input logic [11:0] v);
    @(posedge i_clk_sys);
    #5 o_pins = v;
  endtask
endmodule
`default_nettype wire

// ==== tb/programmable_array_output_stage_test.sv ====
// programmable_array_output_stage_test.sv: self-checking bench
// assumes output k of the array equals data input k
`timescale 1ns/1ns
`default_nettype none
module programmable_array_output_stage_test;
  logic i_clk_sys = 1'b0, i_rst = 1'b1, ce = 1'b1;
  logic [11:0] p;
  logic [7:0] o_q, last = 8'h00, cur;
  logic [31:0] rnd = 32'hA9CEE665;
  logic [7:0] exp_q[$];
  int fails = 0, checks_done = 0, i;
  event probe;
  initial forever #50 i_clk_sys = ~i_clk_sys;
  paos_sys_model u_sys (.i_clk_sys(i_clk_sys), .o_pins(p));
  paos_core #(.NT(1), .COMP_MASK(128'h0), .TERM_USED(8'hFF), .TRUE_MASK({16'h0080,
    16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h0001})) DUT (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(ce), .i_data(p[11:4]),
    .i_clock_group_a(p[3]), .i_clock_group_b(p[2]), .i_master_clear(p[1]),
    .i_out_disable(p[0]), .i_io(4'h0), .o_q(o_q), .o_io(), .o_io_oe());
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic step(input logic [11:0] v, input int n, input logic [7:0] e);
    u_sys.drive(v);
    repeat (n) @(posedge i_clk_sys);
    #5 exp_q.push_back(e);
    ->probe;
  endtask
  task automatic compare_q;
    cur = exp_q.pop_front();
    checks_done++;
    if (o_q !== cur) begin
      fails++;
      $display("Error o_q expected %h seen %h", cur, o_q);
    end
  endtask
  always @(probe) compare_q();
  task automatic test_done;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000 fails++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge i_clk_sys);
    #5 i_rst = 1'b0;
    step(12'h000, 1, 8'h00);
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      step({rnd[7:0], 4'h0}, 3, last);
      step({rnd[7:0], i[0], ~i[0], 2'b00}, 4, rnd[7:0]);
      last = rnd[7:0];
      step({~rnd[7:0], i[0], ~i[0], 2'b00}, 4, last);
    end
    $display("load test done");
    step({8'h00, 4'b0001}, 4, 8'h00);
    step(12'h000, 4, last);
    $display("disable test done");
    step({8'hFF, 4'b1010}, 4, 8'h00);
    step({8'hFF, 4'h0}, 6, 8'h00);
    $display("clear test done");
    ce = 1'b0;
    step({8'h5A, 4'b1000}, 4, 8'h00);
    ce = 1'b1;
    step({8'h5A, 4'b1000}, 4, 8'h5A);
    $display("enable test done");
    test_done();
  end
endmodule
`default_nettype wire
